// ===== phy_evt_pkg.sv
// shared constants and carriers for the link/phy event counter bank
package phy_evt_pkg;

  // counter slots held by the bank, in log order
  localparam int unsigned NUM_SLOTS   = 11;
  localparam int unsigned SLOT_IDX_W  = 4;
  localparam int unsigned ID_W        = 16;
  localparam int unsigned VAL_W       = 64;
  localparam int unsigned CNT_W_DFLT  = 16;
  localparam int unsigned WORD_BITS   = 16;
  localparam int unsigned INC_W       = 2;

  // identifier layout
  localparam int unsigned ID_CODE_LSB = 0;
  localparam int unsigned ID_CODE_W   = 12;
  localparam int unsigned ID_SIZE_LSB = 12;
  localparam int unsigned ID_SIZE_W   = 3;
  localparam int unsigned ID_VEND_BIT = 15;

  // identifier codes, bits 11:0
  localparam logic [11:0] ID_END        = 12'h000;
  localparam logic [11:0] ID_CMD_INTERFACE_CRC_FLAG   = 12'h001;
  localparam logic [11:0] ID_DATA_ALL   = 12'h002;
  localparam logic [11:0] ID_DATA_TX    = 12'h003;
  localparam logic [11:0] ID_DATA_RX    = 12'h004;
  localparam logic [11:0] ID_NDATA_ALL  = 12'h005;
  localparam logic [11:0] ID_NDATA_TX   = 12'h006;
  localparam logic [11:0] ID_NDATA_RX   = 12'h007;
  localparam logic [11:0] ID_PHY_UP     = 12'h009;
  localparam logic [11:0] ID_SIG_FIS    = 12'h00a;
  localparam logic [11:0] ID_RX_CRC     = 12'h00b;
  localparam logic [11:0] ID_RX_OTHER   = 12'h00d;

  // slot positions
  localparam int unsigned S_CMD_INTERFACE_CRC_FLAG  = 0;
  localparam int unsigned S_DATA_ALL  = 1;
  localparam int unsigned S_DATA_TX   = 2;
  localparam int unsigned S_DATA_RX   = 3;
  localparam int unsigned S_NDATA_ALL = 4;
  localparam int unsigned S_NDATA_TX  = 5;
  localparam int unsigned S_NDATA_RX  = 6;
  localparam int unsigned S_PHY_UP    = 7;
  localparam int unsigned S_SIG_FIS   = 8;
  localparam int unsigned S_RX_CRC    = 9;
  localparam int unsigned S_RX_OTHER  = 10;

  // reset value of every counter
  localparam logic [VAL_W-1:0] CNT_RST = 64'h0000_0000_0000_0000;

  // one-cycle event strobes from the link and transport layers
  typedef struct packed {
    logic cmd_fail_interface_crc_flag;   // ending status err set with interface_crc_flag set
    logic tx_data_errp;    // d2h data fis answered by host with r_errp
    logic rx_data_errp;    // h2d data fis answered by us with r_errp
    logic tx_ndata_errp;   // d2h non-data fis (each retry) answered with r_errp
    logic rx_ndata_errp;   // h2d non-data fis (each retry) answered with r_errp
    logic rx_errp_crc;     // h2d fis of any type rejected for crc
    logic rx_errp_other;   // h2d fis of any type rejected for other cause
    logic sig_fis_rok;     // reset signature fis after comreset, host gave r_ok
    logic bist_activate;   // bist activate fis received
  } link_evt_s;

  // one log entry as returned to the log formatter
  typedef struct packed {
    logic [ID_W-1:0]  id;
    logic [VAL_W-1:0] value;
  } log_entry_s;

endpackage : phy_evt_pkg

// ===== phy_evt_counters.sv
// bank of link and phy event counters reported in the phy event log page
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - identifier zero has no counter; it marks end of the counter list.
// - count commands ending with err status and interface crc flag set.
// - count d2h data fises host r_errp'd plus h2d data fises we r_errp'd.
// - count only d2h data fises answered by host with r_errp.
// - count h2d data fises we r_errp'd; need not equal crc/non-crc split.
// - count non-data r_errp in both directions summed, every retry included.
// - count d2h non-data fises host r_errp'd, each retry counted.
// - count h2d non-data fises we r_errp'd, each retry counted.
// - count each not-ready to ready phy transition, whatever the cause.
// - power management link transitions may also advance the phy counter.
// - count reset signature register fises after comreset acked with r_ok.
// - count h2d fises of any type r_errp'd because of crc error.
// - count h2d fises of any type r_errp'd for non-crc causes.
// - counters saturate at all ones, one-extended to reported width.
// - a received bist activate fis returns all counters to reset value.
// - log read with features bit 0 returns values, then clears all.
// - identifier bits 14:12 encode width: 1=16,2=32,3=48,4=64 bits.

module phy_evt_counters #(
  parameter int unsigned CNT_W = phy_evt_pkg::CNT_W_DFLT
) (
  // clock and reset
  input  wire logic                               core_clk,
  input  wire logic                               rstn,
  // event strobes, same clock
  input  wire phy_evt_pkg::link_evt_s             evt,
  // phy ready level, from the phy's own timing
  input  wire logic                               phy_rdy,
  // log read port
  input  wire logic                               log_req,
  input  wire logic [phy_evt_pkg::SLOT_IDX_W-1:0] log_idx,
  input  wire logic                               log_done,
  input  wire logic                               log_clear_req,
  output logic                                    log_ack,
  output phy_evt_pkg::log_entry_s                 log_entry
);

  ////////////////////////////////////////////////////////////////////////////
  // derived widths

  // reported width rounds the physical width up to whole 16-bit words
  localparam int unsigned NWORDS = (CNT_W + phy_evt_pkg::WORD_BITS - 1) /
                                   phy_evt_pkg::WORD_BITS;
  localparam int unsigned REP_W  = NWORDS * phy_evt_pkg::WORD_BITS;
  localparam logic [phy_evt_pkg::ID_SIZE_W-1:0] SIZE_CODE = 3'(NWORDS);

  localparam logic [CNT_W-1:0] CNT_MAX  = {CNT_W{1'b1}};
  localparam logic [CNT_W-1:0] CNT_ZERO = CNT_W'(phy_evt_pkg::CNT_RST);

  ////////////////////////////////////////////////////////////////////////////
  // functions

  // saturating add of 0, 1 or 2 events; never wraps
  function automatic logic [CNT_W-1:0] sat_add(
    input logic [CNT_W-1:0]              cur,
    input logic [phy_evt_pkg::INC_W-1:0] inc
  );
    logic [CNT_W:0] sum;
    sum = {1'b0, cur} + (CNT_W+1)'(inc);
    if (sum[CNT_W]) begin
      sat_add = CNT_MAX;
    end else begin
      sat_add = sum[CNT_W-1:0];
    end
  endfunction : sat_add

  // identifier code for a slot; past the last slot the end marker
  function automatic logic [phy_evt_pkg::ID_CODE_W-1:0] slot_code(
    input logic [phy_evt_pkg::SLOT_IDX_W-1:0] idx
  );
    unique case (idx)
      4'h0:    slot_code = phy_evt_pkg::ID_CMD_INTERFACE_CRC_FLAG;
      4'h1:    slot_code = phy_evt_pkg::ID_DATA_ALL;
      4'h2:    slot_code = phy_evt_pkg::ID_DATA_TX;
      4'h3:    slot_code = phy_evt_pkg::ID_DATA_RX;
      4'h4:    slot_code = phy_evt_pkg::ID_NDATA_ALL;
      4'h5:    slot_code = phy_evt_pkg::ID_NDATA_TX;
      4'h6:    slot_code = phy_evt_pkg::ID_NDATA_RX;
      4'h7:    slot_code = phy_evt_pkg::ID_PHY_UP;
      4'h8:    slot_code = phy_evt_pkg::ID_SIG_FIS;
      4'h9:    slot_code = phy_evt_pkg::ID_RX_CRC;
      4'ha:    slot_code = phy_evt_pkg::ID_RX_OTHER;
      default: slot_code = phy_evt_pkg::ID_END;
    endcase
  endfunction : slot_code

  // one bit of event into an increment
  function automatic logic [phy_evt_pkg::INC_W-1:0] one(input logic b);
    one = {1'b0, b};
  endfunction : one

  ////////////////////////////////////////////////////////////////////////////
  // phy ready synchroniser and rising edge

  logic phy_rdy_m_ff;
  logic phy_rdy_s_ff;
  logic phy_rdy_d_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      phy_rdy_m_ff <= 1'b0;
      phy_rdy_s_ff <= 1'b0;
      phy_rdy_d_ff <= 1'b0;
    end else begin
      phy_rdy_m_ff <= phy_rdy;
      phy_rdy_s_ff <= phy_rdy_m_ff;
      phy_rdy_d_ff <= phy_rdy_s_ff;
    end
  end

  // any cause counts, power management wake-ups included
  wire phy_up = phy_rdy_s_ff & ~phy_rdy_d_ff;

  ////////////////////////////////////////////////////////////////////////////
  // increments per slot

  logic [phy_evt_pkg::INC_W-1:0] inc [phy_evt_pkg::NUM_SLOTS];

  // the summing slots add two when both directions fire in one cycle
  assign inc[phy_evt_pkg::S_CMD_INTERFACE_CRC_FLAG]  = one(evt.cmd_fail_interface_crc_flag);
  assign inc[phy_evt_pkg::S_DATA_ALL]  = one(evt.tx_data_errp) +
                                         one(evt.rx_data_errp);
  assign inc[phy_evt_pkg::S_DATA_TX]   = one(evt.tx_data_errp);
  assign inc[phy_evt_pkg::S_DATA_RX]   = one(evt.rx_data_errp);
  assign inc[phy_evt_pkg::S_NDATA_ALL] = one(evt.tx_ndata_errp) +
                                         one(evt.rx_ndata_errp);
  assign inc[phy_evt_pkg::S_NDATA_TX]  = one(evt.tx_ndata_errp);
  assign inc[phy_evt_pkg::S_NDATA_RX]  = one(evt.rx_ndata_errp);
  assign inc[phy_evt_pkg::S_PHY_UP]    = one(phy_up);
  assign inc[phy_evt_pkg::S_SIG_FIS]   = one(evt.sig_fis_rok);
  assign inc[phy_evt_pkg::S_RX_CRC]    = one(evt.rx_errp_crc);
  assign inc[phy_evt_pkg::S_RX_OTHER]  = one(evt.rx_errp_other);

  ////////////////////////////////////////////////////////////////////////////
  // clear requests

  // clear after the read completes, so the values read are the pre-clear ones
  wire read_clear = log_done & log_clear_req;
  wire clear_all  = read_clear | evt.bist_activate;

  ////////////////////////////////////////////////////////////////////////////
  // counters

  logic [CNT_W-1:0] cnt_ff  [phy_evt_pkg::NUM_SLOTS];
  logic [CNT_W-1:0] nxt_cnt [phy_evt_pkg::NUM_SLOTS];

  // an event in the clearing cycle is kept: it counts from zero
  for (genvar g = 0; g < phy_evt_pkg::NUM_SLOTS; g++) begin : g_next
    assign nxt_cnt[g] = sat_add(clear_all ? CNT_ZERO : cnt_ff[g], inc[g]);
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < phy_evt_pkg::NUM_SLOTS; i++) begin
        cnt_ff[i] <= CNT_ZERO;
      end
    end else begin
      for (int i = 0; i < phy_evt_pkg::NUM_SLOTS; i++) begin
        cnt_ff[i] <= nxt_cnt[i];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // log entry lookup

  wire              slot_ok  = log_idx < phy_evt_pkg::SLOT_IDX_W'(phy_evt_pkg::NUM_SLOTS);
  wire [CNT_W-1:0]  slot_cnt = slot_ok ? cnt_ff[log_idx] : CNT_ZERO;
  wire              slot_sat = slot_ok & (slot_cnt == CNT_MAX);

  // a saturated narrow counter reads as all ones over its reported words
  wire [REP_W-1:0]  rep_val  = slot_sat ? {REP_W{1'b1}} : REP_W'(slot_cnt);

  wire [phy_evt_pkg::ID_W-1:0] slot_id =
    slot_ok ? {1'b0, SIZE_CODE, slot_code(log_idx)} :
              phy_evt_pkg::ID_W'(phy_evt_pkg::ID_END);

  phy_evt_pkg::log_entry_s nxt_entry;
  assign nxt_entry.id    = slot_id;
  assign nxt_entry.value = phy_evt_pkg::VAL_W'(rep_val);

  ////////////////////////////////////////////////////////////////////////////
  // log answer registers

  logic                    ack_ff;
  phy_evt_pkg::log_entry_s entry_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ack_ff   <= 1'b0;
      entry_ff <= '0;
    end else begin
      ack_ff   <= log_req;
      if (log_req) begin
        entry_ff <= nxt_entry;
      end
    end
  end

  assign log_ack   = ack_ff;
  assign log_entry = entry_ff;

endmodule : phy_evt_counters
`default_nettype wire

// ===== phy_evt_counters_chk.sv
// assertions on the log port of the event counter bank
`timescale 1ns/1ps
`default_nettype none
module phy_evt_counters_chk #(
  parameter int unsigned CNT_W = 16
) (
  input wire logic                               core_clk,
  input wire logic                               rstn,
  input wire phy_evt_pkg::link_evt_s             evt,
  input wire logic                               log_req,
  input wire logic [phy_evt_pkg::SLOT_IDX_W-1:0] log_idx,
  input wire logic                               log_done,
  input wire logic                               log_clear_req,
  input wire logic                               log_ack,
  input wire phy_evt_pkg::log_entry_s            log_entry
);
  localparam int unsigned SZ = (CNT_W + 15) / 16;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_ack_after_req: assert property (log_req |=> log_ack)
    else $error("ack missing after request");
  a_ack_only_req: assert property (log_ack |-> $past(log_req))
    else $error("ack without request");
  a_entry_holds: assert property (!log_req |=> $stable(log_entry))
    else $error("entry changed without request");
  a_end_marker: assert property (log_req && log_idx > 4'ha |=> log_entry == '0)
    else $error("end marker not zero");
  a_size_code: assert property (log_req && log_idx < 4'hb |=>
    log_entry.id[15:12] == 4'(SZ)) else $error("bad size code");
  a_first_code: assert property (log_req && log_idx == 4'h0 |=>
    log_entry.id[11:0] == 12'h001) else $error("bad first identifier");
  a_value_width: assert property (log_req |=>
    (log_entry.value >> (16 * SZ)) == 64'h0) else $error("value wider than size");
  a_bist_clear: assert property ((evt == 9'h001) ##1 (log_req && log_idx != 4'h7)
    |=> log_entry.value == 64'h0) else $error("bist did not clear");
  a_read_clear: assert property ((log_done && log_clear_req && evt == 9'h000)
    ##1 (evt == 9'h000 && !log_req) ##1 (log_req && log_idx != 4'h7)
    |=> log_entry.value == 64'h0)
    else $error("read clear failed");
endmodule : phy_evt_counters_chk
bind phy_evt_counters phy_evt_counters_chk #(.CNT_W(CNT_W)) chk_i (.core_clk, .rstn, .evt,
  .log_req, .log_idx, .log_done, .log_clear_req, .log_ack, .log_entry);
`default_nettype wire

// ===== host_link_model.sv
// far-side link model: turns bench commands into link event strobes and phy ready
`timescale 1ns/1ps
`default_nettype none
module host_link_model (
  // clock and reset
  input  wire logic                   core_clk,
  input  wire logic                   rstn,
  // commands from the bench
  input  wire phy_evt_pkg::link_evt_s go,
  input  wire logic                   rdy_go,
  // link side
  output var  phy_evt_pkg::link_evt_s evt,
  output var  logic                   phy_rdy
);
  // one stage: the link layer reports a finished fis a cycle late
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      evt     <= '0;
      phy_rdy <= 1'b0;
    end else begin
      evt     <= go;
      phy_rdy <= rdy_go;
    end
  end
endmodule : host_link_model
`default_nettype wire

// ===== tb.sv
// self-checking bench for the event counter bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin errors++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end
module tb;
  logic                    core_clk = 1'b0;
  logic                    rstn = 1'b0;
  phy_evt_pkg::link_evt_s  go = '0;
  logic                    rdy_go = 1'b0;
  phy_evt_pkg::link_evt_s  evt;
  logic                    phy_rdy;
  logic                    log_req = 1'b0;
  logic [3:0]              log_idx = 4'h0;
  logic                    log_done = 1'b0;
  logic                    log_clear_req = 1'b0;
  logic                    log_ack;
  phy_evt_pkg::log_entry_s log_entry;
  int                      errors = 0;
  int                      samples_checked = 0;
  logic [11:0] codes [11] = '{12'h001, 12'h002, 12'h003, 12'h004, 12'h005, 12'h006,
                              12'h007, 12'h009, 12'h00a, 12'h00b, 12'h00d};
  // slots touched by each strobe bit, bist bit first
  logic [10:0] masks [9] = '{11'h000, 11'h100, 11'h400, 11'h200, 11'h050, 11'h030,
                             11'h00a, 11'h006, 11'h001};
  int          exp_cnt [11];
  ////////////////////////////////////////////////////////////////////////////
  host_link_model MODEL (.core_clk, .rstn, .go, .rdy_go, .evt, .phy_rdy);
  phy_evt_counters #(.CNT_W(16)) DUT (.core_clk, .rstn, .evt, .phy_rdy, .log_req,
    .log_idx, .log_done, .log_clear_req, .log_ack, .log_entry);
  initial begin
    forever #25 core_clk = ~core_clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic stop_test();
    if (errors == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : stop_test
  task automatic rd(input logic [3:0] i, input logic [15:0] eid, input logic [63:0] ev);
    int n;
    n = 0;
    @(posedge core_clk);
    log_req <= 1'b1;
    log_idx <= i;
    @(posedge core_clk);
    log_req <= 1'b0;
    #1;
    while (log_ack !== 1'b1 && n < 4) begin
      @(posedge core_clk);
      #1;
      n++;
    end
    if (n == 4) begin
      $display("BAD log_ack exp 1 got %b", log_ack);
      errors++;
      stop_test();
    end
    `CHK("log id", eid, log_entry.id)
    `CHK("log value", ev, log_entry.value)
  endtask : rd
  task automatic rd_all();
    for (int s = 0; s < 16; s++) begin
      if (s < 11) rd(4'(s), {4'h1, codes[s]}, 64'(exp_cnt[s]));
      else rd(4'(s), 16'h0000, 64'h0);
    end
  endtask : rd_all
  task automatic fire(input logic [8:0] bits, input int n);
    @(posedge core_clk);
    go <= bits;
    repeat (n) @(posedge core_clk);
    go <= '0;
  endtask : fire
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_events();
    // strobe b is held b cycles so each slot total is unique
    for (int b = 1; b < 9; b++) begin
      fire(9'(1 << b), b);
      for (int s = 0; s < 11; s++) exp_cnt[s] += masks[b][s] ? b : 0;
    end
    fire(9'h0c0, 1);
    exp_cnt[1] += 2;
    exp_cnt[2] += 1;
    exp_cnt[3] += 1;
    // both non-data directions in one cycle must add two to the summing slot
    fire(9'h030, 1);
    exp_cnt[4] += 2;
    exp_cnt[5] += 1;
    exp_cnt[6] += 1;
    repeat (3) begin
      @(posedge core_clk);
      rdy_go <= 1'b1;
      repeat (4) @(posedge core_clk);
      rdy_go <= 1'b0;
      repeat (4) @(posedge core_clk);
    end
    exp_cnt[7] += 3;
    repeat (4) @(posedge core_clk);
    rd_all();
  endtask : t_events
  task automatic t_clear();
    @(posedge core_clk);
    log_done <= 1'b1;
    @(posedge core_clk);
    log_done <= 1'b0;
    rd(4'h0, 16'h1001, 64'(exp_cnt[0]));
    @(posedge core_clk);
    log_done <= 1'b1;
    log_clear_req <= 1'b1;
    @(posedge core_clk);
    log_done <= 1'b0;
    log_clear_req <= 1'b0;
    rd(4'h1, 16'h1002, 64'h0);
    fire(9'h080, 2);
    fire(9'h001, 1);
    rd(4'h1, 16'h1002, 64'h0);
    // an event in the clearing cycle survives the clear
    fire(9'h081, 1);
    rd(4'h2, 16'h1003, 64'h1);
  endtask : t_clear
  task automatic t_sat();
    // holding the strobe for 65540 cycles runs the 16-bit counter past its top
    fire(9'h100, 65540);
    repeat (2) @(posedge core_clk);
    rd(4'h0, 16'h1001, 64'hffff);
  endtask : t_sat
  initial begin
    foreach (exp_cnt[s]) exp_cnt[s] = 0;
    repeat (6) @(posedge core_clk);
    rstn <= 1'b1;
    rd_all();
    t_events();
    t_clear();
    t_sat();
    stop_test();
  end
endmodule : tb
`default_nettype wire
